// >>> core/emulator_monitor_entry.sv
// monitor entry logic: break interrupt, breakpoints, hung cycles, apb regs
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "monitor_entry_params.svh"
module emulator_monitor_entry
	import monitor_entry_pkg::*;
#(
	parameter int NUM_BKPT = 8,
	parameter int AW = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] tgt_ipl,
	output logic [2:0] cpu_ipl,
	input wire logic cyc_start,
	input wire logic cyc_iack,
	input wire logic cyc_bkack,
	input wire logic cyc_fetch,
	input wire logic cyc_write,
	input wire logic [AW-1:0] cyc_addr,
	input wire logic [2:0] cyc_mask,
	input wire logic cyc_master,
	input wire logic tgt_ta,
	input wire logic tgt_tea,
	output logic tgt_show,
	output logic trace_show,
	output logic cpu_ta,
	output logic data_oe,
	output logic [31:0] data_out,
	output logic [2:0] mon_mask,
	output logic master_stack
);
	// target pin inputs go through two flops; first stage read only by second
	logic [2:0] ipl_s1_ff, ipl_ff;
	logic [1:0] ta_s1_ff, ta_ff;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ipl_s1_ff <= 3'h0;
			ipl_ff <= 3'h0;
			ta_s1_ff <= 2'h0;
			ta_ff <= 2'h0;
		end else begin
			ipl_s1_ff <= tgt_ipl;
			ipl_ff <= ipl_s1_ff;
			ta_s1_ff <= {tgt_tea, tgt_ta};
			ta_ff <= ta_s1_ff;
		end
	end

	// registers
	logic [2:0] ctrl_ff;
	logic [2:0] monlvl_ff;
	logic [31:0] vector_ff;
	logic [15:0] hanglim_ff;
	logic [NUM_BKPT-1:0] bken_ff;
	logic [AW-1:0] bkaddr_ff [NUM_BKPT];
	logic in_mon_ff, failed_ff, hung_ff;
	entry_state_t state_ff;
	logic [15:0] hang_cnt_ff;
	logic cyc_open_ff;

	wire wr_acc = psel & penable & pwrite;
	wire rd_acc = psel & penable & ~pwrite;
	wire entering = (state_ff != ENT_IDLE) && (state_ff != ENT_DONE)
		&& (state_ff != ENT_FAIL);

	// breakpoint slot index decode, used for read and write
	function automatic logic slot_hit(input logic [11:0] a, input int i);
		slot_hit = (a == 12'(`ADDR_BKPT_BASE + 4 * i));
	endfunction : slot_hit

	// control writes; break request self-clears once entry starts
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= 3'h0;
			monlvl_ff <= 3'h0;
			vector_ff <= `VECTOR_RST;
			hanglim_ff <= `HANG_LIMIT_RST;
			bken_ff <= '0;
		end else begin
			if (wr_acc && paddr == `ADDR_CTRL) begin
				ctrl_ff <= pwdata[2:0];
			end else if (state_ff == ENT_ACK) begin
				ctrl_ff[`CTRL_BREAK] <= 1'b0;
			end
			if (wr_acc && paddr == `ADDR_MONLVL) begin
				monlvl_ff <= pwdata[2:0];
			end
			if (wr_acc && paddr == `ADDR_VECTOR) begin
				vector_ff <= pwdata;
			end
			if (wr_acc && paddr == `ADDR_HANGLIM) begin
				hanglim_ff <= pwdata[15:0];
			end
			if (wr_acc && paddr == `ADDR_BKPT_EN) begin
				bken_ff <= pwdata[NUM_BKPT-1:0];
			end
		end
	end

	// breakpoint address slots, compared on logical fetch addresses
	genvar g;
	logic [NUM_BKPT-1:0] bk_match;
	generate
		for (g = 0; g < NUM_BKPT; g++) begin : g_bk
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					bkaddr_ff[g] <= '0;
				end else if (wr_acc && slot_hit(paddr, g)) begin
					bkaddr_ff[g] <= pwdata[AW-1:0];
				end
			end
			// logical compare, independent of translation
			assign bk_match[g] = bken_ff[g] && cyc_addr == bkaddr_ff[g];
		end
	endgenerate
	// substitution on fetch only when memory could not be written
	wire bk_subst = cyc_start & cyc_fetch & ~cyc_write & (|bk_match)
		& ctrl_ff[`CTRL_BKPT_ENABLE];
	wire bkack_take = cyc_start & cyc_bkack & ctrl_ff[`CTRL_BKPT_ENABLE];

	// apb read mux; unmapped reads zero with slave error
	logic [31:0] nxt_prdata;
	logic nxt_err;
	always_comb begin
		nxt_prdata = 32'h0;
		nxt_err = 1'b0;
		case (paddr)
			`ADDR_CTRL: nxt_prdata = {29'h0, ctrl_ff};
			`ADDR_MONLVL: nxt_prdata = {29'h0, monlvl_ff};
			`ADDR_VECTOR: nxt_prdata = vector_ff;
			`ADDR_HANGLIM: nxt_prdata = {16'h0, hanglim_ff};
			`ADDR_STATUS: nxt_prdata = {28'h0, entering, hung_ff,
				failed_ff, in_mon_ff};
			`ADDR_BKPT_EN: nxt_prdata = {{(32-NUM_BKPT){1'b0}}, bken_ff};
			default: nxt_err = 1'b1;
		endcase
		for (int i = 0; i < NUM_BKPT; i++) begin
			if (slot_hit(paddr, i)) begin
				nxt_prdata = 32'(bkaddr_ff[i]);
				nxt_err = 1'b0;
			end
		end
	end

	// no wait state: answer in the cycle after setup
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & nxt_err;
			if (psel & ~penable & ~pwrite) begin
				prdata <= nxt_prdata;
			end
		end
	end

	// hung cycle counter during entry cycles
	wire cyc_end_tgt = ta_ff[0] | ta_ff[1];
	wire hang_hit = cyc_open_ff && hang_cnt_ff >= hanglim_ff;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cyc_open_ff <= 1'b0;
			hang_cnt_ff <= 16'h0;
		end else if (cyc_start && entering && !cyc_bkack) begin
			cyc_open_ff <= 1'b1;
			hang_cnt_ff <= 16'h0;
		end else if (cyc_end_tgt || hang_hit) begin
			cyc_open_ff <= 1'b0;
		end else if (cyc_open_ff) begin
			hang_cnt_ff <= hang_cnt_ff + 16'h1;
		end
	end

	// entry sequencer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ENT_IDLE;
		end else begin
			case (state_ff)
				ENT_IDLE: begin
					if (bkack_take) begin
						state_ff <= ENT_STACK;
					end else if (ctrl_ff[`CTRL_BREAK]) begin
						state_ff <= ENT_ACK;
					end
				end
				ENT_ACK: if (cyc_start && cyc_iack) state_ff <= ENT_STACK;
				ENT_STACK, ENT_VEC: begin
					// any exception kills the break
					if (cyc_open_ff && ta_ff[1]) begin
						state_ff <= ENT_FAIL;
					end else if (cyc_start && !cyc_write && !cyc_fetch) begin
						state_ff <= ENT_VEC;
					end else if (state_ff == ENT_VEC && cyc_start && cyc_fetch) begin
						state_ff <= ENT_DONE;
					end
				end
				ENT_DONE: if (ctrl_ff[`CTRL_BREAK]) state_ff <= ENT_ACK;
				ENT_FAIL: if (ctrl_ff[`CTRL_BREAK]) state_ff <= ENT_ACK;
				default: state_ff <= ENT_IDLE;
			endcase
		end
	end

	// sticky failed and hung status, in_mon_ff follows ENT_DONE; set wins over clear by status write
	wire st_clr = wr_acc && paddr == `ADDR_STATUS;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			in_mon_ff <= 1'b0;
			failed_ff <= 1'b0;
			hung_ff <= 1'b0;
		end else begin
			in_mon_ff <= (state_ff == ENT_DONE);
			if (state_ff == ENT_FAIL) failed_ff <= 1'b1;
			else if (st_clr && pwdata[`ST_FAILED]) failed_ff <= 1'b0;
			if (hang_hit) hung_ff <= 1'b1;
			else if (st_clr && pwdata[`ST_HUNG]) hung_ff <= 1'b0;
		end
	end

	// interrupt lines: break forces level 7, rest of entry forces 0, else pass target level through
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cpu_ipl <= 3'h0;
		end else if (state_ff == ENT_ACK) begin
			cpu_ipl <= `BREAK_LEVEL;
		end else if (entering) begin
			cpu_ipl <= 3'h0;
		end else begin
			cpu_ipl <= ipl_ff; // target request kept, not latched
		end
	end

	// bus visibility, termination and data drive
	wire brk_ack = state_ff == ENT_ACK && cyc_start && cyc_iack;
	// data only on the vector read, never on the monitor's own fetches
	wire vec_fetch = state_ff == ENT_VEC && cyc_start && !cyc_write
		&& !cyc_fetch;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tgt_show <= 1'b1;
			trace_show <= 1'b1;
			cpu_ta <= 1'b0;
			data_oe <= 1'b0;
			data_out <= 32'h0;
		end else begin
			tgt_show <= ~brk_ack;
			trace_show <= ~brk_ack | ctrl_ff[`CTRL_BG_TRACE];
			// acks end at once, no target wait
			cpu_ta <= brk_ack | bkack_take | hang_hit;
			data_oe <= brk_ack | vec_fetch | bk_subst;
			if (vec_fetch) begin
				data_out <= vector_ff;
			end else if (bk_subst) begin
				data_out <= {`BKPT_OPCODE, 16'h0};
			end else begin
				data_out <= 32'h0;
			end
		end
	end

	// mask level and stacking info on entry
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mon_mask <= 3'h7;
			master_stack <= 1'b0;
		end else if (brk_ack || bkack_take) begin
			mon_mask <= (monlvl_ff > cyc_mask) ? monlvl_ff : cyc_mask;
			master_stack <= cyc_master;
		end
	end

	// assertions
	AST_BREAK_LVL: assert property (@(posedge core_clk) disable iff (rst)
		state_ff == ENT_ACK |=> cpu_ipl == 3'h7)
		else $error("break level not 7");
	AST_HIDE_ACK: assert property (@(posedge core_clk) disable iff (rst)
		brk_ack |=> !tgt_show)
		else $error("break ack shown to target");
	AST_TRACE: assert property (@(posedge core_clk) disable iff (rst)
		brk_ack && !ctrl_ff[2] |=> !trace_show)
		else $error("break ack shown to trace");
	AST_VECTOR: assert property (@(posedge core_clk) disable iff (rst)
		vec_fetch |=> data_oe && data_out == $past(vector_ff))
		else $error("vector data wrong");
	AST_BLOCK: assert property (@(posedge core_clk) disable iff (rst)
		entering && state_ff != ENT_ACK && $past(entering) |=> cpu_ipl == 3'h0)
		else $error("interrupt not blocked");
	AST_MASK: assert property (@(posedge core_clk) disable iff (rst)
		brk_ack |=> mon_mask >= $past(monlvl_ff) && mon_mask >= $past(cyc_mask))
		else $error("mask not max");
	AST_HUNG: assert property (@(posedge core_clk) disable iff (rst)
		hang_hit |=> cpu_ta && hung_ff)
		else $error("hung cycle not ended");
	AST_BKACK: assert property (@(posedge core_clk) disable iff (rst)
		bkack_take && state_ff == ENT_IDLE |=> cpu_ta && tgt_show)
		else $error("bkpt ack not ended at once");
endmodule : emulator_monitor_entry
`default_nettype wire

// >>> core/monitor_entry_params.svh
// constants for the monitor entry block
// How it works
// - break asserts level 7 nonmaskable interrupt request to the processor
// - break request merges with pending target interrupts without losing them
// - break interrupt acknowledge cycle is hidden from the target bus
// - break acknowledge hidden from trace unless background tracing selected
// - emulator drives vector fetch data pointing at the monitor
// - further interrupts blocked while entry is in progress
// - mask set to max of monitor level and target mask level
// - break stacking goes to foreground memory at interrupt stack pointer
// - master mode target program also stacks on the master stack
// - any exception during entry makes the break fail
// - unterminated stacking or vector cycle is force terminated, entry completes
// - with breakpoints enabled a breakpoint instruction causes entry when the sequencer is in ENT_IDLE
// - breakpoint written to memory first, else substituted on fetch
// - eight hardware address match resources substitute breakpoint opcodes
// - breakpoint addresses are always compared as logical addresses
// - breakpoint acknowledge starts entry, then same as interrupt break
// - breakpoint acknowledge cycle stays visible on the target bus
// - emulator terminates breakpoint acknowledge immediately by itself
`ifndef MONITOR_ENTRY_PARAMS_SVH
`define MONITOR_ENTRY_PARAMS_SVH
`define ADDR_CTRL 12'h000
`define ADDR_MONLVL 12'h004
`define ADDR_VECTOR 12'h008
`define ADDR_HANGLIM 12'h00C
`define ADDR_STATUS 12'h010
`define ADDR_BKPT_EN 12'h014
`define ADDR_BKPT_BASE 12'h020
`define CTRL_BREAK 0
`define CTRL_BKPT_ENABLE 1
`define CTRL_BG_TRACE 2
`define ST_IN_MON 0
`define ST_FAILED 1
`define ST_HUNG 2
`define ST_BUSY 3
`define BREAK_LEVEL 3'h7
`define BKPT_OPCODE 16'h484F
`define HANG_LIMIT_RST 16'h0100
`define VECTOR_RST 32'h00000000
`endif

// >>> core/monitor_entry_pkg.sv
// types for the monitor entry block
package monitor_entry_pkg;
	typedef enum logic [2:0] {
		ENT_IDLE = 3'b000,
		ENT_ACK = 3'b001,
		ENT_STACK = 3'b011,
		ENT_VEC = 3'b010,
		ENT_DONE = 3'b110,
		ENT_FAIL = 3'b111
	} entry_state_t;
endpackage : monitor_entry_pkg

// >>> sim/emulator_monitor_entry_test.sv
// self-checking bench for the monitor entry block
`timescale 1ns/100ps
`default_nettype none
`include "monitor_entry_params.svh"
module emulator_monitor_entry_test;
	logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, data_out;
	logic [31:0] cyc_addr = 32'h0;
	logic pready, pslverr, err_bit, tgt_ta, tgt_tea, hang = 0, berr = 0;
	logic [2:0] tgt_ipl = 3'h0, cyc_mask = 3'h0, cpu_ipl, mon_mask;
	logic cyc_start = 0, cyc_iack = 0, cyc_bkack = 0, cyc_fetch = 0;
	logic cyc_write = 0, cyc_master = 0;
	logic tgt_show, trace_show, cpu_ta, data_oe, master_stack;
	logic [3:0] slow = 4'h1;
	int failures = 0, comparisons = 0, k;

	always #10 core_clk = ~core_clk;

	emulator_monitor_entry uut (.core_clk(core_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tgt_ipl(tgt_ipl), .cpu_ipl(cpu_ipl),
		.cyc_start(cyc_start), .cyc_iack(cyc_iack), .cyc_bkack(cyc_bkack),
		.cyc_fetch(cyc_fetch), .cyc_write(cyc_write), .cyc_addr(cyc_addr),
		.cyc_mask(cyc_mask), .cyc_master(cyc_master), .tgt_ta(tgt_ta),
		.tgt_tea(tgt_tea), .tgt_show(tgt_show), .trace_show(trace_show),
		.cpu_ta(cpu_ta), .data_oe(data_oe), .data_out(data_out),
		.mon_mask(mon_mask), .master_stack(master_stack));

	target_bus_model far (.core_clk(core_clk), .rst(rst),
		.cyc_start(cyc_start), .cyc_bkack(cyc_bkack), .hang(hang),
		.berr(berr), .wait_cyc(slow), .tgt_ta(tgt_ta), .tgt_tea(tgt_tea));

	task print_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// apb transfer; request held until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err_bit = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
		if (n == 20) begin
			chk(32'h0, 32'h1);
			print_verdict();
		end
	endtask : apb

	// one-clock start pulse; qualifiers stay until the next cycle
	task cyc(input logic [3:0] t, input logic [31:0] a);
		{cyc_iack, cyc_bkack, cyc_fetch, cyc_write} <= t;
		cyc_addr <= a;
		cyc_start <= 1;
		@(posedge core_clk);
		cyc_start <= 0;
	endtask : cyc

	// bounded wait: 0 level 7, 1 emulator termination, 2 data drive
	task wt(input int s);
		int n;
		for (n = 0; n < 40; n++) begin
			@(posedge core_clk);
			if (s == 0 && cpu_ipl === 3'h7) return;
			if (s == 1 && cpu_ta === 1'b1) return;
			if (s == 2 && data_oe === 1'b1) return;
		end
		chk(32'h0, 32'h1);
		print_verdict();
	endtask : wt

	// m: 0 break, 1 break traced and hung, 2 break with bus error, 3 bkpt
	task entry(input int m);
		int j;
		rst <= 1;
		hang <= 0;
		berr <= 0;
		slow <= (m == 3) ? 4'h4 : 4'h1;
		cyc_mask <= (m == 3) ? 3'h6 : 3'h2;
		cyc_master <= (m == 1);
		repeat (2) @(posedge core_clk);
		rst <= 0;
		apb(1, `ADDR_MONLVL, 32'h5);
		apb(1, `ADDR_VECTOR, 32'h000016C2);
		apb(1, `ADDR_HANGLIM, 32'h8);
		if (m == 3) begin
			for (j = 0; j < 8; j++)
				apb(1, `ADDR_BKPT_BASE + 12'(4 * j), 32'h80000000 + 16 * j);
			for (j = 0; j < 8; j++) begin
				apb(0, `ADDR_BKPT_BASE + 12'(4 * j), 32'h0);
				chk(rd, 32'h80000000 + 16 * j);
			end
			apb(1, `ADDR_BKPT_EN, 32'h80);
			apb(1, `ADDR_CTRL, 32'h2);
			cyc(4'b0010, 32'h80000070);
			wt(2);
			chk({16'h0, data_out[31:16]}, 32'h484F);
			repeat (12) @(posedge core_clk);
			cyc(4'b0100, 32'h0);
			wt(1);
			chk(tgt_show, 1);
		end else begin
			tgt_ipl <= 3'h3;
			repeat (6) @(posedge core_clk);
			chk(cpu_ipl, 3);
			apb(1, `ADDR_CTRL, (m == 1) ? 32'h5 : 32'h1);
			wt(0);
			cyc(4'b1000, 32'hFFFFFFFF);
			wt(1);
			chk(tgt_show, 0);
			chk(trace_show, (m == 1));
		end
		// stacking write; the model may hang or err on it
		hang <= (m == 1);
		berr <= (m == 2);
		repeat (4) @(posedge core_clk);
		chk(cpu_ipl, 0);
		chk(master_stack, (m == 1));
		cyc(4'b0001, 32'h0000F0EE);
		if (m == 1)
			wt(1);
		repeat (14) @(posedge core_clk);
		if (m == 2) begin
			apb(0, `ADDR_STATUS, 32'h0);
			chk(rd[1], 1);
			return;
		end
		cyc(4'b0000, 32'h0000007C);
		repeat (14) @(posedge core_clk);
		cyc(4'b0000, 32'h0000007C);
		wt(2);
		chk(data_out, 32'h000016C2);
		repeat (14) @(posedge core_clk);
		// monitor fetched at its untranslated address
		cyc(4'b0010, 32'h000016C0);
		repeat (14) @(posedge core_clk);
		apb(0, `ADDR_STATUS, 32'h0);
		chk(rd[0], 1);
		if (m == 1)
			chk(rd[2], 1);
		chk(mon_mask, (m == 3) ? 6 : 5);
	endtask : entry

	// reset, register checks, then the four entry runs
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 0;
		apb(0, `ADDR_HANGLIM, 32'h0);
		chk(rd, 32'h100);
		apb(0, 12'hFFC, 32'h0);
		chk({rd[30:0], err_bit}, 32'h1);
		$display("test registers done");
		for (k = 0; k < 4; k++) begin
			entry(k);
			$display("test entry %0d done", k);
		end
		print_verdict();
	end
endmodule : emulator_monitor_entry_test
`default_nettype wire

// >>> sim/target_bus_model.sv
// behavioural target bus: ends cycles after a wait, hangs or errs on request
`timescale 1ns/100ps
`default_nettype none
module target_bus_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cyc_start,
	input wire logic cyc_bkack,
	input wire logic hang,
	input wire logic berr,
	input wire logic [3:0] wait_cyc,
	output logic tgt_ta,
	output logic tgt_tea
);
	logic [4:0] cnt_ff;

	// wait counter; breakpoint acks are left unanswered by the target
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 5'h00;
		end else if (cyc_start && !cyc_bkack && !hang) begin
			cnt_ff <= {1'b0, wait_cyc} + 5'h01;
		end else if (cnt_ff != 5'h00) begin
			cnt_ff <= cnt_ff - 5'h01;
		end
	end

	// one-cycle strobe; a bus error replaces the normal termination
	assign tgt_ta = (cnt_ff == 5'h01) && !berr;
	assign tgt_tea = (cnt_ff == 5'h01) && berr;
endmodule : target_bus_model
`default_nettype wire
